/* logic/qdfs_defs.svh */
// How it works
// R1: alert ignores triggers while its pulse runs
// R2: faults during lockout still latch, readable later
// R3: alert is open-drain, wire-OR capable
// R4: one overtemp, one openload flag per channel
// R5: shift out MSB first on rising SCK
// R6: sample serial input on falling SCK
// R7: bits 0-3 overtemp A-D, 4-7 openload A-D
// R8: devices chain, all shift together
// R9: chip select fall loads flags first
// R10: host holds SCK low at select
// R11: output drives low until first rise
// R12: host keeps SCK low at deselect
// R13: host clocks bits without interruption
// R14: reset clears flags, keeps shift register
// R15: reset holds all four drivers off
// R16: host clears shift register via select after reset
// R17: floating reset line reads inactive high
// R18: low supply turns all drivers off
// R19: host resets after supply dip before trusting
// R20: OR of flags triggers low alert pulse
// R21: openload cleared on falling control, resets
// R22: overtemp latches driver off, sets flag
// R23: rising control releases latch, repeats if persisting
// R24: serial output released while deselected
`ifndef QDFS_DEFS_SVH
`define QDFS_DEFS_SVH

// system clock
`define QDFS_CLK_NS 50
// channels and fault register layout
`define QDFS_NCH 4
`define QDFS_FAULT_W 8
`define QDFS_OT_LSB 0
`define QDFS_OL_LSB 4
`define QDFS_FAULT_MSB 7
`define QDFS_FAULT_RESET 8'h00
// alert pulse, least width
`define QDFS_ALERT_PULSE_NS 3000
`define QDFS_ALERT_CYCLES ((`QDFS_ALERT_PULSE_NS + `QDFS_CLK_NS - 1) / `QDFS_CLK_NS)
`define QDFS_ALERT_CNT_W 8
// host link timing, least times
`define QDFS_SCK_HALF_NS 250
`define QDFS_LEAD_NS 250
`define QDFS_LAG_NS 250
`define QDFS_SCK_HALF_CYCLES ((`QDFS_SCK_HALF_NS + `QDFS_CLK_NS - 1) / `QDFS_CLK_NS)
`define QDFS_LEAD_CYCLES ((`QDFS_LEAD_NS + `QDFS_CLK_NS - 1) / `QDFS_CLK_NS)
`define QDFS_LAG_CYCLES ((`QDFS_LAG_NS + `QDFS_CLK_NS - 1) / `QDFS_CLK_NS)
`define QDFS_TCNT_W 4

`endif

/* logic/qdfs_pkg.sv */
package qdfs_pkg;
  // fault register: openload in high nibble, overtemp in low nibble
  typedef struct packed {
    logic [3:0] openload;
    logic [3:0] overtemp;
  } qdfs_flags_t;

  // host link sequencer
  typedef enum logic [2:0] {
    QDFS_H_IDLE = 3'b000,
    QDFS_H_LEAD = 3'b001,
    QDFS_H_HIGH = 3'b010,
    QDFS_H_LOW = 3'b011,
    QDFS_H_LAG = 3'b100
  } qdfs_hstate_t;
endpackage : qdfs_pkg

/* logic/qdfs_if.sv */
`timescale 1ns/1ps
interface qdfs_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_o;
  logic so_oe;
  logic so;
  logic alert_o;
  logic alert_oe;
  logic alert_n;
  logic rst_o;
  logic rst_oe;
  logic rst_n;

  // wire levels worked out from the enables
  assign so = so_oe ? so_o : !so_o; // no keeper: a released line shows the inverse
  assign alert_n = alert_oe ? alert_o : 1'b1; // pull-up on shared alert
  assign rst_n = rst_oe ? rst_o : 1'b1; // R17

  modport dev (
    input cs_n,
    input sck,
    input si,
    input rst_n,
    output so_o,
    output so_oe,
    output alert_o,
    output alert_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    output rst_o,
    output rst_oe,
    input so,
    input alert_n
  );
endinterface : qdfs_if

/* logic/qdfs_device.sv */
`timescale 1ns/1ps
`include "qdfs_defs.svh"
module qdfs_device #(
  parameter int NCH = `QDFS_NCH
) (
  input logic mclk,
  input logic rstn,
  qdfs_if.dev link,
  input logic [NCH-1:0] ctrl_in,
  input logic [NCH-1:0] overtemp_sense,
  input logic [NCH-1:0] openload_sense,
  input logic supply_low,
  output logic [NCH-1:0] drive_out,
  output qdfs_pkg::qdfs_flags_t fault_bits,
  output logic alert_active
);
  import qdfs_pkg::*;

  // ---- system clock domain ----

  // synchroniser stages for pins
  logic [NCH-1:0] ctrl_s1_r;
  logic [NCH-1:0] ctrl_s2_r;
  logic [NCH-1:0] ctrl_d_r;
  logic [NCH-1:0] ot_s1_r;
  logic [NCH-1:0] ot_s2_r;
  logic [NCH-1:0] ol_s1_r;
  logic [NCH-1:0] ol_s2_r;
  logic rst_s1_r;
  logic rst_s2_r;
  logic sup_s1_r;
  logic sup_s2_r;
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_d_r;

  // per channel flag state
  logic [NCH-1:0] ot_flag_r;
  logic [NCH-1:0] ot_flag_nxt;
  logic [NCH-1:0] ol_flag_r;
  logic [NCH-1:0] ol_flag_nxt;
  logic [NCH-1:0] latch_off_r;
  logic [NCH-1:0] latch_off_nxt;
  logic [NCH-1:0] drive_r;
  logic [NCH-1:0] drive_nxt;
  logic [NCH-1:0] ctrl_rise;
  logic [NCH-1:0] ctrl_fall;

  // snapshot handed to the link domain
  logic [`QDFS_FAULT_W-1:0] snap_r;
  logic [`QDFS_FAULT_W-1:0] flags_w;
  logic cs_fall;

  // alert one-shot
  logic [`QDFS_ALERT_CNT_W-1:0] alert_cnt_r;
  logic [`QDFS_ALERT_CNT_W-1:0] alert_cnt_nxt;
  logic any_fault;
  logic any_fault_d_r;
  logic alert_trig;
  logic alert_busy;

  // reset and supply qualifiers
  logic rst_ok;
  logic supply_ok;

  // two-stage synchronisers for every pin input except sck and si
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_s1_r <= '0;
      ctrl_s2_r <= '0;
      ot_s1_r <= '0;
      ot_s2_r <= '0;
      ol_s1_r <= '0;
      ol_s2_r <= '0;
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
      sup_s1_r <= 1'b1;
      sup_s2_r <= 1'b1;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
    end else begin
      ctrl_s1_r <= ctrl_in;
      ctrl_s2_r <= ctrl_s1_r;
      ot_s1_r <= overtemp_sense;
      ot_s2_r <= ot_s1_r;
      ol_s1_r <= openload_sense;
      ol_s2_r <= ol_s1_r;
      rst_s1_r <= link.rst_n;
      rst_s2_r <= rst_s1_r;
      sup_s1_r <= supply_low;
      sup_s2_r <= sup_s1_r;
      cs_s1_r <= link.cs_n;
      cs_s2_r <= cs_s1_r;
    end
  end

  // qualifiers from synchronised pins
  assign rst_ok = rst_s2_r;
  assign supply_ok = !sup_s2_r;
  assign ctrl_rise = ctrl_s2_r & ~ctrl_d_r;
  assign ctrl_fall = ~ctrl_s2_r & ctrl_d_r;

  // per channel fault flags, gate latch and driver
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      // overtemp: set wins over release by rising control
      assign ot_flag_nxt[i] = !rst_ok ? 1'b0 : // R14
                              ot_s2_r[i] ? 1'b1 : // R22 R2
                              ctrl_rise[i] ? 1'b0 : ot_flag_r[i]; // R23
      // gate latch forced off regardless of control level
      assign latch_off_nxt[i] = !rst_ok ? 1'b0 :
                                ot_s2_r[i] ? 1'b1 : // R22
                                ctrl_rise[i] ? 1'b0 : latch_off_r[i]; // R23
      // openload: only sensed with output off, set wins over clear
      assign ol_flag_nxt[i] = !rst_ok ? 1'b0 : // R14
                              (ol_s2_r[i] && !ctrl_s2_r[i]) ? 1'b1 : // R21 R2
                              ctrl_fall[i] ? 1'b0 : ol_flag_r[i]; // R21
      // driver on only when commanded, not latched, not in reset, supply good
      assign drive_nxt[i] = ctrl_s2_r[i] && !latch_off_nxt[i] &&
                            rst_ok && supply_ok; // R15 R18
    end
  endgenerate

  // flag and driver registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_d_r <= '0;
      ot_flag_r <= '0;
      ol_flag_r <= '0;
      latch_off_r <= '0;
      drive_r <= '0;
    end else begin
      ctrl_d_r <= ctrl_s2_r;
      ot_flag_r <= ot_flag_nxt;
      ol_flag_r <= ol_flag_nxt;
      latch_off_r <= latch_off_nxt;
      drive_r <= drive_nxt;
    end
  end

  // fault register layout
  assign flags_w = {ol_flag_r, ot_flag_r}; // R4 R7
  assign fault_bits = qdfs_flags_t'(flags_w);
  assign drive_out = drive_r;

  // chip select fall seen in this domain
  assign cs_fall = cs_d_r && !cs_s2_r;

  // snapshot of the flags, stable for the whole frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_d_r <= 1'b1;
      snap_r <= `QDFS_FAULT_RESET;
    end else begin
      cs_d_r <= cs_s2_r;
      if (cs_fall) begin
        snap_r <= flags_w; // R9
      end
    end
  end

  // alert trigger from the OR of all flags
  assign any_fault = |flags_w; // R20
  assign alert_trig = any_fault && !any_fault_d_r;
  assign alert_busy = (alert_cnt_r != '0);
  // a running pulse ignores new triggers
  assign alert_cnt_nxt = alert_busy ? alert_cnt_r - 1'b1 : // R1
                         alert_trig ? `QDFS_ALERT_CNT_W'(`QDFS_ALERT_CYCLES) : '0; // R20

  // one-shot counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      any_fault_d_r <= 1'b0;
      alert_cnt_r <= '0;
    end else begin
      any_fault_d_r <= any_fault;
      alert_cnt_r <= alert_cnt_nxt;
    end
  end

  // open-drain alert: pull low only while pulsing
  assign link.alert_o = 1'b0; // R3
  assign link.alert_oe = alert_busy; // R3 R20
  assign alert_active = alert_busy;

  // ---- link clock domain ----

  // so_r is the last stage, so seven bits hold the rest and no pad bit enters the chain
  logic [`QDFS_FAULT_W-2:0] shreg_r;
  logic so_r;
  logic si_r;
  logic loaded_r;

  // serial input sampled on falling clock
  always_ff @(negedge link.sck) begin
    si_r <= link.si; // R6
  end

  // shift out on rising clock; first edge takes the snapshot
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      loaded_r <= 1'b0;
      so_r <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
      if (!loaded_r) begin
        so_r <= snap_r[`QDFS_FAULT_MSB]; // R5
      end else begin
        so_r <= shreg_r[`QDFS_FAULT_MSB-1]; // R5 R8
      end
    end
  end

  // shift register data, untouched by the reset line
  always_ff @(posedge link.sck) begin
    if (!link.cs_n) begin
      if (!loaded_r) begin
        shreg_r <= snap_r[`QDFS_FAULT_MSB-1:0]; // R14
      end else begin
        shreg_r <= {shreg_r[`QDFS_FAULT_MSB-2:0], si_r}; // R8
      end
    end
  end

  // drive while selected, low until the first rising clock
  assign link.so_o = loaded_r ? so_r : 1'b0; // R11
  assign link.so_oe = !link.cs_n; // R11 R24
endmodule : qdfs_device

/* logic/qdfs_host.sv */
`timescale 1ns/1ps
`include "qdfs_defs.svh"
module qdfs_host #(
  parameter int NBITS = `QDFS_FAULT_W
) (
  input logic mclk,
  input logic rstn,
  qdfs_if.host link,
  input logic start,
  input logic [NBITS-1:0] tx_data,
  input logic reset_req,
  output logic busy,
  output logic done,
  output logic [NBITS-1:0] rx_data,
  output logic alert_seen
);
  import qdfs_pkg::*;

  qdfs_hstate_t state_r;
  qdfs_hstate_t state_nxt;
  logic [`QDFS_TCNT_W-1:0] tcnt_r;
  logic [15:0] bitcnt_r;
  logic [NBITS-1:0] tx_r;
  logic [NBITS-1:0] rx_r;
  logic cs_n_r;
  logic sck_r;
  logic si_r;
  logic done_r;
  logic rst_r;
  logic so_s1_r;
  logic so_s2_r;
  logic al_s1_r;
  logic al_s2_r;
  logic tdone;
  logic last_bit;

  // sequencer conditions
  assign tdone = (tcnt_r == '0);
  assign last_bit = (bitcnt_r == 16'(NBITS));

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      QDFS_H_IDLE: if (start) state_nxt = QDFS_H_LEAD;
      QDFS_H_LEAD: if (tdone) state_nxt = QDFS_H_HIGH;
      QDFS_H_HIGH: if (tdone) state_nxt = QDFS_H_LOW;
      QDFS_H_LOW: if (tdone) state_nxt = last_bit ? QDFS_H_LAG : QDFS_H_HIGH; // R13
      QDFS_H_LAG: if (tdone) state_nxt = QDFS_H_IDLE;
      default: state_nxt = QDFS_H_IDLE;
    endcase
  end

  // pin synchronisers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      so_s1_r <= 1'b0;
      so_s2_r <= 1'b0;
      al_s1_r <= 1'b1;
      al_s2_r <= 1'b1;
    end else begin
      so_s1_r <= link.so;
      so_s2_r <= so_s1_r;
      al_s1_r <= link.alert_n;
      al_s2_r <= al_s1_r;
    end
  end

  // frame sequencer and clock divider
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= QDFS_H_IDLE;
      tcnt_r <= '0;
      bitcnt_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      cs_n_r <= 1'b1;
      sck_r <= 1'b0;
      si_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r <= 1'b0;
      if (!tdone) begin
        tcnt_r <= tcnt_r - 1'b1;
      end
      case (state_r)
        QDFS_H_IDLE: if (start) begin
          cs_n_r <= 1'b0; // R10
          sck_r <= 1'b0;
          tx_r <= tx_data;
          bitcnt_r <= '0;
          tcnt_r <= `QDFS_TCNT_W'(`QDFS_LEAD_CYCLES - 1);
        end
        QDFS_H_LEAD, QDFS_H_LOW: if (tdone) begin
          if (state_r == QDFS_H_LOW && last_bit) begin
            tcnt_r <= `QDFS_TCNT_W'(`QDFS_LAG_CYCLES - 1); // R12
          end else begin
            sck_r <= 1'b1;
            si_r <= tx_r[NBITS-1];
            tx_r <= {tx_r[NBITS-2:0], 1'b0};
            tcnt_r <= `QDFS_TCNT_W'(`QDFS_SCK_HALF_CYCLES - 1);
          end
        end
        QDFS_H_HIGH: if (tdone) begin
          sck_r <= 1'b0;
          rx_r <= {rx_r[NBITS-2:0], so_s2_r};
          bitcnt_r <= bitcnt_r + 16'd1;
          tcnt_r <= `QDFS_TCNT_W'(`QDFS_SCK_HALF_CYCLES - 1);
        end
        QDFS_H_LAG: if (tdone) begin
          cs_n_r <= 1'b1; // R12
          done_r <= 1'b1;
        end
        default: cs_n_r <= 1'b1;
      endcase
    end
  end

  // reset line driven low on request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_r <= 1'b0;
    end else begin
      rst_r <= reset_req; // R16 R19
    end
  end

  // link pins and user outputs
  assign link.cs_n = cs_n_r;
  assign link.sck = sck_r;
  assign link.si = si_r;
  assign link.rst_o = 1'b0;
  assign link.rst_oe = rst_r;
  assign busy = (state_r != QDFS_H_IDLE);
  assign done = done_r;
  assign rx_data = rx_r;
  assign alert_seen = !al_s2_r;
endmodule : qdfs_host

/* bench/qdfs_link_properties.sv */
`timescale 1ns/1ps
module qdfs_link_properties (
  input logic mclk,
  input logic rstn,
  input logic cs_n,
  input logic sck,
  input logic si,
  input logic so_o,
  input logic so_oe,
  input logic alert_o,
  input logic alert_oe
);
  logic rise_seen_r;
  logic rise_seen_nxt;
  logic [6:0] alert_cnt_r;
  logic [6:0] alert_cnt_nxt;

  // first sck rise of a frame, and length of the running alert pulse
  assign rise_seen_nxt = !cs_n && (rise_seen_r || sck);
  assign alert_cnt_nxt = alert_oe ? alert_cnt_r + 7'h01 : 7'h00;

  // helper state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rise_seen_r <= 1'b0;
      alert_cnt_r <= 7'h00;
    end else begin
      rise_seen_r <= rise_seen_nxt;
      alert_cnt_r <= alert_cnt_nxt;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  so_release_a: assert property (cs_n |-> !so_oe)
    else $error("so driven while deselected");
  so_low_a: assert property (!cs_n && !sck && !rise_seen_r |-> so_oe && !so_o)
    else $error("so not low before first rise");
  sck_lead_a: assert property ($fell(cs_n) |-> !sck)
    else $error("sck high at select");
  sck_lag_a: assert property ($rose(cs_n) |-> !sck)
    else $error("sck high at deselect");
  sck_run_a: assert property ($rose(sck) |-> sck[*5] ##1 !sck)
    else $error("sck high phase broken");
  so_steady_a: assert property (!cs_n && !$past(cs_n) && !$rose(sck) |-> $stable(so_o))
    else $error("so moved off a rising sck");
  si_steady_a: assert property ($fell(sck) |-> $stable(si))
    else $error("si moved at sampling edge");
  alert_len_a: assert property ($fell(alert_oe) |-> alert_cnt_r == 7'h3c)
    else $error("alert pulse width wrong");
  alert_lock_a: assert property (alert_oe |-> alert_cnt_r < 7'h3c)
    else $error("alert pulse stretched");
  alert_od_a: assert property (alert_oe |-> !alert_o)
    else $error("alert driven high");

  // main scenarios reached
  frame_c: cover property ($fell(cs_n));
  alert_c: cover property ($fell(alert_oe));
  data_c: cover property ($rose(sck) && so_o);
endmodule : qdfs_link_properties

/* bench/quad_driver_fault_spi_link_tb.sv */
`timescale 1ns/1ps
module quad_driver_fault_spi_link_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] ctrl_in = 4'h0;
  logic [3:0] overtemp_sense = 4'h0;
  logic [3:0] openload_sense = 4'h0;
  logic supply_low = 1'b0;
  logic start = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic reset_req = 1'b0;
  logic [3:0] drive_out;
  qdfs_pkg::qdfs_flags_t fault_bits;
  logic alert_active, busy, done, alert_seen;
  logic [15:0] rx_data;
  int mismatches = 0;
  int checked = 0;

  qdfs_if link_if ();
  qdfs_device u_qdfs_device (.mclk(mclk), .rstn(rstn), .link(link_if), .ctrl_in(ctrl_in),
    .overtemp_sense(overtemp_sense), .openload_sense(openload_sense),
    .supply_low(supply_low), .drive_out(drive_out), .fault_bits(fault_bits),
    .alert_active(alert_active));
  // two bytes per frame: the device's own, then the upstream bits it passes on
  qdfs_host #(.NBITS(16)) u_qdfs_host (.mclk(mclk), .rstn(rstn), .link(link_if), .start(start),
    .tx_data(tx_data), .reset_req(reset_req), .busy(busy), .done(done),
    .rx_data(rx_data), .alert_seen(alert_seen));
  qdfs_link_properties u_qdfs_link_properties (.mclk(mclk), .rstn(rstn),
    .cs_n(link_if.cs_n), .sck(link_if.sck), .si(link_if.si), .so_o(link_if.so_o),
    .so_oe(link_if.so_oe), .alert_o(link_if.alert_o), .alert_oe(link_if.alert_oe));

  // system clock
  always #25 mclk = ~mclk;

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // one host transfer, bounded wait for done
  task automatic frame(input logic [7:0] exp, input string msg);
    int n;
    n = 0;
    start = 1'b1;
    tx_data = 16'h5a00;
    cyc(1);
    start = 1'b0;
    chk({7'h00, busy}, 8'h01, "busy after start");
    while (done !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    // lead 5, thirty-two half periods of 5, lag 5
    chk({6'h00, busy, done}, 8'h01, "done ends frame");
    chk(8'(n), 8'haa, "frame length");
    chk(rx_data[15:8], exp, msg);
    chk(rx_data[7:0], tx_data[15:8], "upstream byte passed");
    cyc(1);
  endtask : frame

  // pulse the link reset line from the host
  task automatic clear_faults();
    reset_req = 1'b1;
    cyc(5);
    chk(fault_bits, 8'h00, "flags in reset");
    chk({4'h0, drive_out}, 8'h00, "drivers in reset");
    reset_req = 1'b0;
    cyc(6);
    chk({7'h00, link_if.rst_n}, 8'h01, "reset line idle");
  endtask : clear_faults

  task automatic test_bit_map();
    for (int i = 0; i < 8; i++) begin
      clear_faults();
      if (i < 4) overtemp_sense[i] = 1'b1;
      else openload_sense[i-4] = 1'b1;
      cyc(5);
      overtemp_sense = 4'h0;
      openload_sense = 4'h0;
      chk(fault_bits, 8'h01 << i, "flag position");
      frame(8'h01 << i, "single flag read");
    end
  endtask : test_bit_map

  task automatic test_drive();
    // drivers commanded on before the reset, so the reset has something to switch off
    ctrl_in = 4'hf;
    clear_faults();
    cyc(6);
    chk({4'h0, drive_out}, 8'h0f, "all on");
    overtemp_sense[2] = 1'b1;
    cyc(5);
    overtemp_sense = 4'h0;
    cyc(5);
    chk({4'h0, drive_out}, 8'h0b, "hot channel latched off");
    ctrl_in = 4'hb;
    cyc(5);
    ctrl_in = 4'hf;
    cyc(6);
    chk({4'h0, drive_out}, 8'h0f, "latch released");
    supply_low = 1'b1;
    cyc(5);
    chk({4'h0, drive_out}, 8'h00, "low supply");
    supply_low = 1'b0;
    ctrl_in = 4'hd;
    openload_sense[1] = 1'b1;
    cyc(5);
    openload_sense = 4'h0;
    cyc(2);
    chk(fault_bits, 8'h20, "openload held");
    ctrl_in = 4'hf;
    cyc(5);
    ctrl_in = 4'hd;
    cyc(6);
    chk(fault_bits, 8'h00, "openload cleared on fall");
  endtask : test_drive

  task automatic test_alert();
    int n;
    int w;
    ctrl_in = 4'h0;
    clear_faults();
    cyc(70);
    overtemp_sense[0] = 1'b1;
    cyc(3);
    overtemp_sense[0] = 1'b0;
    w = 0;
    while (link_if.alert_n !== 1'b0 && w < 10) begin
      cyc(1);
      w++;
    end
    // mid-pulse: drop the OR by a rising control, then raise it again by a new openload
    n = 0;
    while (link_if.alert_n === 1'b0 && n < 100) begin
      n++;
      if (n == 10) ctrl_in[0] = 1'b1;
      if (n == 20) begin
        chk(fault_bits, 8'h00, "overtemp released in pulse");
        openload_sense[3] = 1'b1;
        chk({6'h00, alert_seen, alert_active}, 8'h03, "alert flagged");
      end
      cyc(1);
    end
    chk(8'(n), 8'h3c, "alert width");
    w = 0;
    repeat (80) begin
      cyc(1);
      if (link_if.alert_n !== 1'b1) w++;
    end
    chk(8'(w), 8'h00, "no second pulse");
    frame(8'h80, "flags from lockout");
    overtemp_sense = 4'h0;
    openload_sense = 4'h0;
    ctrl_in = 4'h0;
  endtask : test_alert

  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    #1 rstn = 1'b1;
    cyc(2);
    clear_faults();
    frame(8'h00, "cleared load");
    test_bit_map();
    test_drive();
    test_alert();
    finish_test();
  end

  // hang guard
  initial begin
    #(20000 * 50);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule : quad_driver_fault_spi_link_tb
